/* src/pecqs_top.sv */
// Extended control and quick-poll detailed status registers of a 10/100 PHY.
// Assumes a management frame engine decodes reads/writes into one-cycle strobes.
// Behaviour
// - latch PHY address from pins at hw reset
// - software reset keeps PHY address
// - scrambler test mode forces lock loss
// - NRZ when bit zero, NRZI when one
// - test bit zero: standard 4B/5B only
// - test bit plus TX error: test mapping
// - nibbles 0-7 leading zero, 8 zero
// - nibbles 9-F use fixed test codes
// - scrambler disable bypasses scrambler and descrambler
// - scrambling only in 100 Mbps mode
// - status register read-only, reset defaults
// - rate bit follows pin or control
// - duplex bit follows pin or control
// - eight event flags latch high, default zero
// - two idles before delimiter flags premature
// - negotiation complete bit not latching
// - progress rises only, except a read reloads the current state; cleared on disable/restart
// - sticky-high flags clear on read or reset; link latch sets on read, clears on link loss or reset
// - reserved bits read zero
`timescale 1ns/100ps
module pecqs_top (
   // Clock and resets
   input wire logic clock,
   input wire logic rst,
   input wire logic hw_reset_done,
   input wire logic sw_reset,
   // Strap pins shared with status indicators
   input wire logic [4:0] addr_strap_pins,
   // Management register access
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // Mode selection
   input wire logic hw_mode,
   input wire logic rate_select_pin,
   input wire logic duplex_select_pin,
   input wire logic ctrl_rate_100,
   input wire logic ctrl_duplex_full,
   input wire logic an_enable,
   input wire logic an_restart,
   // Datapath status events
   input wire logic [2:0] an_state,
   input wire logic an_complete,
   input wire logic signal_present,
   input wire logic link_valid,
   input wire logic [pecqs_pkg::PECQS_NUM_EVT-1:0] evt_in,
   input wire logic rx_sym_valid,
   input wire logic rx_sym_idle,
   input wire logic rx_sym_end,
   // Transmit path
   input wire logic [3:0] tx_nibble,
   input wire logic tx_error,
   input wire logic [4:0] tx_std_sym,
   input wire logic tx_serial_in,
   output logic [4:0] tx_sym,
   output logic tx_serial_out,
   // Scrambler control outputs
   output logic scr_force_unlock,
   output logic scr_tx_enable,
   output logic scr_rx_enable,
   output logic [15:0] ext_ctrl_value
);
   import pecqs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Extended control storage
   logic [4:0] phy_addr_reg; // Latched management address
   logic cow_reg; // One-shot override write enable
   logic scr_test_reg; // Scrambler test mode
   logic nrzi_reg; // NRZI select
   logic inv_code_reg; // Invalid-code test enable
   logic scr_dis_reg; // Scrambler disable
   logic [15:0] ext_ctrl; // Assembled read value
   logic wr_ec; // Write to extended control
   logic rd_qs; // Read of quick status
   logic soft_rst; // Software reset or bus reset

   assign wr_ec = reg_wr && (reg_addr == PECQS_ADDR_EXT_CTRL);
   assign rd_qs = reg_rd && (reg_addr == PECQS_ADDR_QSTAT);
   assign soft_rst = rst || sw_reset;

   // Address strap capture after hardware reset release
   always_ff @(posedge clock) begin
      if (rst) begin
         phy_addr_reg <= 5'h00;
      end else if (hw_reset_done) begin
         phy_addr_reg <= addr_strap_pins;
      end
   end

   // Writable control bits; software reset restores defaults
   always_ff @(posedge clock) begin
      if (soft_rst) begin
         cow_reg <= 1'b0;
         scr_test_reg <= PECQS_RST_SCR_TEST;
         nrzi_reg <= PECQS_RST_NRZI;
         inv_code_reg <= PECQS_RST_INV_CODE;
         scr_dis_reg <= PECQS_RST_SCR_DIS;
      end else if (wr_ec) begin
         cow_reg <= reg_wdata[PECQS_EC_COW];
         scr_test_reg <= reg_wdata[PECQS_EC_SCR_TEST];
         nrzi_reg <= reg_wdata[PECQS_EC_NRZI];
         inv_code_reg <= reg_wdata[PECQS_EC_INV_CODE];
         scr_dis_reg <= reg_wdata[PECQS_EC_SCR_DIS];
      end else if (reg_wr) begin
         // Override enable clears itself after any other write
         cow_reg <= 1'b0;
      end
   end

   // Read value of extended control
   always_comb begin
      ext_ctrl = 16'h0000;
      ext_ctrl[PECQS_EC_COW] = cow_reg;
      ext_ctrl[PECQS_EC_ADDR_LO +: 5] = phy_addr_reg;
      ext_ctrl[PECQS_EC_SCR_TEST] = scr_test_reg;
      ext_ctrl[PECQS_EC_NRZI] = nrzi_reg;
      ext_ctrl[PECQS_EC_INV_CODE] = inv_code_reg;
      ext_ctrl[PECQS_EC_SCR_DIS] = scr_dis_reg;
   end
   assign ext_ctrl_value = ext_ctrl;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit and scrambler controls
   logic rate_100; // Selected rate
   logic nrzi_state_reg; // NRZI line level
   pecqs_tx_if tx_bus ();

   assign rate_100 = hw_mode ? rate_select_pin : ctrl_rate_100;
   assign scr_force_unlock = scr_test_reg;
   assign scr_tx_enable = rate_100 && !scr_dis_reg;
   assign scr_rx_enable = rate_100 && !scr_dis_reg;

   // NRZI toggles the line on each one
   always_ff @(posedge clock) begin
      if (soft_rst) begin
         nrzi_state_reg <= 1'b0;
         tx_serial_out <= 1'b0;
      end else begin
         nrzi_state_reg <= nrzi_state_reg ^ tx_serial_in;
         tx_serial_out <= nrzi_reg ? (nrzi_state_reg ^ tx_serial_in) : tx_serial_in;
      end
   end

   assign tx_bus.clk = clock;
   assign tx_bus.nibble = tx_nibble;
   assign tx_bus.alt_map = inv_code_reg && tx_error;
   assign tx_bus.std_sym = tx_std_sym;
   assign tx_sym = tx_bus.sym;

   // Symbol selector
   pecqs_code_map u_map (
      .tx(tx_bus.map)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Quick-poll status
   logic [PECQS_NUM_EVT-1:0] evt_all; // Events including premature end
   logic [PECQS_NUM_EVT-1:0] sticky_high_flag_reg; // Latched events
   logic sticky_low_flag_reg; // Link latch
   logic [2:0] max_progress_latch_reg; // Highest negotiation state
   logic [3:0] idle_cnt_reg; // Idles seen before delimiter
   logic premature_evt; // Two idles without delimiter
   pecqs_rx_state_t rx_state_reg;
   logic [15:0] qstat; // Assembled status

   always_ff @(posedge clock) begin
      if (soft_rst) begin
         rx_state_reg <= PECQS_RX_NORMAL;
         idle_cnt_reg <= 4'h0;
      end else if (rx_sym_valid) begin
         case (rx_state_reg)
            PECQS_RX_NORMAL: begin
               // Stream in progress, watch for idle
               if (rx_sym_idle) begin
                  rx_state_reg <= PECQS_RX_ONE_IDLE;
                  idle_cnt_reg <= 4'h1;
               end
            end
            PECQS_RX_ONE_IDLE: begin
               // Second idle before end is premature
               if (rx_sym_end) begin
                  rx_state_reg <= PECQS_RX_NORMAL;
                  idle_cnt_reg <= 4'h0;
               end else if (rx_sym_idle) begin
                  rx_state_reg <= PECQS_RX_DONE;
                  idle_cnt_reg <= PECQS_IDLE_RUN;
               end else begin
                  rx_state_reg <= PECQS_RX_NORMAL;
                  idle_cnt_reg <= 4'h0;
               end
            end
            PECQS_RX_DONE: begin
               // Wait for non-idle to rearm
               if (!rx_sym_idle) begin
                  rx_state_reg <= PECQS_RX_NORMAL;
                  idle_cnt_reg <= 4'h0;
               end
            end
            default: begin
               rx_state_reg <= PECQS_RX_NORMAL;
               idle_cnt_reg <= 4'h0;
            end
         endcase
      end
   end
   assign premature_evt = rx_sym_valid && rx_sym_idle && !rx_sym_end && (rx_state_reg == PECQS_RX_ONE_IDLE);

   always_comb begin
      evt_all = evt_in;
      evt_all[5] = evt_in[5] || premature_evt;
   end

   genvar gi;
   generate
      for (gi = 0; gi < PECQS_NUM_EVT; gi++) begin : g_sticky
         always_ff @(posedge clock) begin
            if (soft_rst) begin
               sticky_high_flag_reg[gi] <= 1'b0;
            end else if (evt_all[gi]) begin
               sticky_high_flag_reg[gi] <= 1'b1;
            end else if (rd_qs) begin
               sticky_high_flag_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (soft_rst) begin
         sticky_low_flag_reg <= 1'b0;
      end else if (!link_valid) begin
         sticky_low_flag_reg <= 1'b0;
      end else if (rd_qs) begin
         sticky_low_flag_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (soft_rst || !an_enable || an_restart) begin
         max_progress_latch_reg <= PECQS_PROG_IDLE;
      end else if (rd_qs) begin
         max_progress_latch_reg <= an_state;
      end else if (an_state > max_progress_latch_reg) begin
         max_progress_latch_reg <= an_state;
      end
   end

   always_comb begin
      qstat = 16'h0000;
      qstat[PECQS_QS_RATE] = rate_100;
      qstat[PECQS_QS_DUPLEX] = hw_mode ? duplex_select_pin : ctrl_duplex_full;
      qstat[PECQS_QS_PROG_LO +: 3] = max_progress_latch_reg;
      // Flag zero (signal lost) sits highest, premature end lowest
      for (int b = 0; b < 6; b++) begin
         qstat[PECQS_QS_SIG_LOST - b] = sticky_high_flag_reg[b];
      end
      qstat[PECQS_QS_AN_DONE] = an_complete;
      qstat[PECQS_QS_SIG_DET_N] = !signal_present;
      qstat[PECQS_QS_JABBER] = sticky_high_flag_reg[6];
      qstat[PECQS_QS_REMOTE] = sticky_high_flag_reg[7];
      qstat[PECQS_QS_LINK] = sticky_low_flag_reg;
   end

   // Read data register; unmapped addresses read zero
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         if (reg_addr == PECQS_ADDR_EXT_CTRL) begin
            reg_rdata <= ext_ctrl;
         end else if (reg_addr == PECQS_ADDR_QSTAT) begin
            reg_rdata <= qstat;
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_sticky_hold;
      @(posedge clock) disable iff (soft_rst) evt_all[0] |=> sticky_high_flag_reg[0];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag missed event");
   property p_read_clear;
      @(posedge clock) disable iff (soft_rst) (rd_qs && evt_all == '0) |=> (sticky_high_flag_reg == '0);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");
   property p_addr_keep;
      @(posedge clock) disable iff (rst) (!hw_reset_done) |=> $stable(phy_addr_reg);
   endproperty
   a_addr_keep: assert property (p_addr_keep) else $error("address changed without strap");
   property p_prog_rise;
      @(posedge clock) disable iff (soft_rst)
         (an_enable && !an_restart && !rd_qs) |=> (max_progress_latch_reg >= $past(max_progress_latch_reg));
   endproperty
   a_prog_rise: assert property (p_prog_rise) else $error("progress fell");
   property p_link_low;
      @(posedge clock) disable iff (soft_rst) !link_valid |=> !sticky_low_flag_reg;
   endproperty
   a_link_low: assert property (p_link_low) else $error("link latch not low");
   property p_scr_rate;
      @(posedge clock) disable iff (rst) !rate_100 |-> !scr_tx_enable && !scr_rx_enable;
   endproperty
   a_scr_rate: assert property (p_scr_rate) else $error("scrambler on at 10 Mbps");
   property p_premature;
      @(posedge clock) disable iff (soft_rst) premature_evt |=> sticky_high_flag_reg[5];
   endproperty
   a_premature: assert property (p_premature) else $error("premature end missed");
   property p_nrz;
      @(posedge clock) disable iff (soft_rst) !nrzi_reg |=> (tx_serial_out == $past(tx_serial_in));
   endproperty
   a_nrz: assert property (p_nrz) else $error("NRZ output wrong");
   property p_rsvd;
      @(posedge clock) disable iff (rst) (ext_ctrl[14:11] == 4'h0) && !ext_ctrl[4] && !ext_ctrl[1];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit not zero");
   c_event: cover property (@(posedge clock) evt_all[2] ##1 rd_qs);
   c_prog: cover property (@(posedge clock) max_progress_latch_reg == 3'h7);
   c_premature: cover property (@(posedge clock) premature_evt);
endmodule

/* src/pecqs_pkg.sv */
// Package for the PHY extended control and quick-poll status block.
// Assumes a management frame engine outside delivers decoded register accesses.
package pecqs_pkg;
   // Register indices on the management bus
   localparam logic [4:0] PECQS_ADDR_EXT_CTRL = 5'h10;
   localparam logic [4:0] PECQS_ADDR_QSTAT = 5'h11;
   // Extended control field positions
   localparam int PECQS_EC_COW = 15;
   localparam int PECQS_EC_ADDR_LO = 6;
   localparam int PECQS_EC_SCR_TEST = 5;
   localparam int PECQS_EC_NRZI = 3;
   localparam int PECQS_EC_INV_CODE = 2;
   localparam int PECQS_EC_SCR_DIS = 0;
   // Reset values of the writable control bits
   localparam logic PECQS_RST_NRZI = 1'b1;
   localparam logic PECQS_RST_SCR_TEST = 1'b0;
   localparam logic PECQS_RST_INV_CODE = 1'b0;
   localparam logic PECQS_RST_SCR_DIS = 1'b0;
   // Quick-poll status field positions
   localparam int PECQS_QS_RATE = 15;
   localparam int PECQS_QS_DUPLEX = 14;
   localparam int PECQS_QS_PROG_LO = 11;
   localparam int PECQS_QS_SIG_LOST = 10;
   localparam int PECQS_QS_AN_DONE = 4;
   localparam int PECQS_QS_SIG_DET_N = 3;
   localparam int PECQS_QS_JABBER = 2;
   localparam int PECQS_QS_REMOTE = 1;
   localparam int PECQS_QS_LINK = 0;
   // Sticky-high event index order: lost, pll, false carrier, invalid, halt, premature, jabber, remote
   localparam int PECQS_NUM_EVT = 8;
   localparam logic [2:0] PECQS_PROG_IDLE = 3'h0;
   localparam logic [3:0] PECQS_IDLE_RUN = 4'h2;
   typedef enum logic [2:0] {
      PECQS_RX_NORMAL = 3'b001,
      PECQS_RX_ONE_IDLE = 3'b010,
      PECQS_RX_DONE = 3'b100
   } pecqs_rx_state_t;
endpackage

/* src/pecqs_tx_if.sv */
// Interface carrying the transmit test-code request between modules.
// Assumes both ends share the device clock.
`timescale 1ns/100ps
interface pecqs_tx_if;
   logic clk; // Device clock, used only to sample the checks
   logic [3:0] nibble; // Transmit nibble from the MAC
   logic alt_map; // Use test-code mapping this cycle
   logic [4:0] std_sym; // Standard symbol from the coder
   logic [4:0] sym; // Chosen symbol
   modport ctrl (output clk, output nibble, output alt_map, output std_sym, input sym);
   modport map (input clk, input nibble, input alt_map, input std_sym, output sym);
endinterface

/* src/pecqs_code_map.sv */
// Transmit symbol selector: standard coder output or the invalid-code test mapping.
// Assumes the standard 4B/5B coder lives outside and feeds std_sym.
`timescale 1ns/100ps
module pecqs_code_map (
   // Request and answer
   pecqs_tx_if.map tx
);
   import pecqs_pkg::*;
   logic [4:0] test_sym; // Test-code symbol for the nibble

   // Test-code lookup
   always_comb begin
      case (tx.nibble)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: test_sym = {1'b0, tx.nibble};
         4'h8: test_sym = 5'h00;
         4'h9: test_sym = 5'h0D;
         4'hA: test_sym = 5'h0C;
         4'hB: test_sym = 5'h11;
         4'hC: test_sym = 5'h10;
         4'hD: test_sym = 5'h19;
         4'hE: test_sym = 5'h18;
         default: test_sym = 5'h1F;
      endcase
   end

   assign tx.sym = tx.alt_map ? test_sym : tx.std_sym;

   property p_low_map;
      @(posedge tx.clk) (tx.alt_map && !tx.nibble[3]) |-> (tx.sym == {1'b0, tx.nibble});
   endproperty
   a_low_map: assert property (p_low_map) else $error("low nibble test code wrong");
   property p_std_pass;
      @(posedge tx.clk) !tx.alt_map |-> (tx.sym == tx.std_sym);
   endproperty
   a_std_pass: assert property (p_std_pass) else $error("standard symbol not passed");
endmodule

/* test/pecqs_sta_model.sv */
// Management entity model: issues one-cycle register reads and writes.
// Assumes the caller calls access just after a falling edge of clock.
`timescale 1ns/100ps
module pecqs_sta_model (
   // Clock
   input wire logic clock,
   // Register access toward the device
   output logic [4:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata
);
   import pecqs_pkg::*;
   ////////////////////////////////////////////////////////////////
   // Quiet bus from time zero
   initial begin
      reg_addr = 5'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   // One access; the strobe spans exactly one rising edge
   task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] data, input int gap);
      reg_addr = addr;
      reg_wr = wr;
      reg_rd = ~wr;
      reg_wdata = (addr == PECQS_ADDR_EXT_CTRL) ? (data & 16'h87ED) : data;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // Released lines must not keep the last value
      reg_addr = ~addr;
      reg_wdata = ~reg_wdata;
      // Slow entity: idle cycles before the next access
      repeat (gap) @(negedge clock);
   endtask
endmodule

/* test/pecqs_top_test.sv */
// Self-checking bench for the extended control and quick-poll status block.
// Assumes the management model above and the package constants of the design.
`timescale 1ns/100ps
module pecqs_top_test;
   import pecqs_pkg::*;
   ////////////////////////////////////////////////////////////////
   // Stimulus and observed signals
   logic clock = 1'b0, rst = 1'b1, hw_reset_done = 1'b0, sw_reset = 1'b0;
   logic [4:0] addr_strap_pins = 5'h15, reg_addr;
   logic reg_wr, reg_rd, hw_mode = 1'b1, rate_select_pin = 1'b1, duplex_select_pin = 1'b1;
   logic [15:0] reg_wdata, reg_rdata, ext_ctrl_value;
   logic ctrl_rate_100 = 1'b0, ctrl_duplex_full = 1'b0, an_enable = 1'b1, an_restart = 1'b0;
   logic [2:0] an_state = 3'h0;
   logic an_complete = 1'b0, signal_present = 1'b1, link_valid = 1'b1;
   logic [PECQS_NUM_EVT-1:0] evt_in = '0;
   logic rx_sym_valid = 1'b0, rx_sym_idle = 1'b0, rx_sym_end = 1'b0;
   logic [3:0] tx_nibble = 4'h0;
   logic [4:0] tx_std_sym = 5'h00, tx_sym;
   logic tx_error = 1'b0, tx_serial_in = 1'b0, tx_serial_out;
   logic scr_force_unlock, scr_tx_enable, scr_rx_enable;
   // Scoreboard state
   logic [15:0] exp_q[$], w;
   logic rd_q = 1'b0, lk = 1'b0, in_p, out_p;
   int failures = 0, n_checks = 0;
   // Test-code symbols for nibbles 0 to F
   localparam logic [4:0] ALT[16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
      5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
   ////////////////////////////////////////////////////////////////
   // 200 MHz clock
   always #2.5 clock = ~clock;
   pecqs_sta_model sta (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata));
   pecqs_top dut (.clock(clock), .rst(rst), .hw_reset_done(hw_reset_done), .sw_reset(sw_reset),
      .addr_strap_pins(addr_strap_pins), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hw_mode(hw_mode), .rate_select_pin(rate_select_pin),
      .duplex_select_pin(duplex_select_pin), .ctrl_rate_100(ctrl_rate_100),
      .ctrl_duplex_full(ctrl_duplex_full), .an_enable(an_enable), .an_restart(an_restart),
      .an_state(an_state), .an_complete(an_complete), .signal_present(signal_present),
      .link_valid(link_valid), .evt_in(evt_in), .rx_sym_valid(rx_sym_valid), .rx_sym_idle(rx_sym_idle),
      .rx_sym_end(rx_sym_end), .tx_nibble(tx_nibble), .tx_error(tx_error), .tx_std_sym(tx_std_sym),
      .tx_serial_in(tx_serial_in), .tx_sym(tx_sym), .tx_serial_out(tx_serial_out),
      .scr_force_unlock(scr_force_unlock), .scr_tx_enable(scr_tx_enable), .scr_rx_enable(scr_rx_enable),
      .ext_ctrl_value(ext_ctrl_value));
   ////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         failures++;
      end
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Expected extended control word; address field keeps the strap value
   function automatic logic [15:0] ext_exp(input logic [15:0] v);
      return {1'b0, 4'h0, 5'h15, v[5], 1'b0, v[3], v[2], 1'b0, v[0]};
   endfunction
   // Expected quick-poll word from the live inputs and the tracked latches
   function automatic logic [15:0] st_exp(input logic [2:0] pg, input logic [7:0] f, input logic l);
      return {hw_mode ? rate_select_pin : ctrl_rate_100, hw_mode ? duplex_select_pin : ctrl_duplex_full,
         pg, f[0], f[1], f[2], f[3], f[4], f[5], an_complete, ~signal_present, f[6], f[7], l};
   endfunction
   // Read with a noted expectation; write without one
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      sta.access(1'b0, a, 16'h0000, 1);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      sta.access(1'b1, a, d, 1);
   endtask
   task automatic tend(input string name);
      $display("test %s done", name);
   endtask
   ////////////////////////////////////////////////////////////////
   // Read data appears one edge after the read strobe
   always @(posedge clock) rd_q <= reg_rd;
   always @(negedge clock) begin
      if (rd_q) begin
         if (exp_q.size() == 0) begin
            chk("unexpected read", 16'h0000, 16'hFFFF);
         end else begin
            chk("reg_rdata", reg_rdata, exp_q.pop_front());
         end
      end
   end
   // Hang guard: a run this long counts as a mismatch
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'hC32C));
      repeat (12) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      hw_reset_done = 1'b1;
      repeat (2) @(negedge clock);
      hw_reset_done = 1'b0;
      // Straps change after capture and must not be seen
      addr_strap_pins = 5'h0A;
      rd(PECQS_ADDR_EXT_CTRL, ext_exp(16'h0008));
      chk("scr_tx_enable", scr_tx_enable, 1'b1);
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b0));
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      tend("reset");
      for (int k = 0; k < 6; k++) begin
         w = 16'($urandom);
         w[15] = 1'b0;
         rate_select_pin = w[8];
         wr(PECQS_ADDR_EXT_CTRL, w);
         chk("ext_ctrl_value", ext_ctrl_value, ext_exp(w));
         chk("scr_force_unlock", scr_force_unlock, w[5]);
         chk("scr_tx_enable", scr_tx_enable, w[8] & ~w[0]);
         chk("scr_rx_enable", scr_rx_enable, w[8] & ~w[0]);
         rd(PECQS_ADDR_EXT_CTRL, ext_exp(w));
      end
      rate_select_pin = 1'b1;
      tend("ext_write");
      sw_reset = 1'b1;
      @(negedge clock);
      sw_reset = 1'b0;
      rd(PECQS_ADDR_EXT_CTRL, ext_exp(16'h0008));
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b0));
      tend("sw_reset");
      wr(PECQS_ADDR_EXT_CTRL, 16'h0004);
      for (int n = 0; n < 16; n++) begin
         tx_nibble = n[3:0];
         tx_std_sym = 5'($urandom);
         tx_error = 1'b1;
         @(negedge clock);
         chk("tx_sym alt", tx_sym, ALT[n]);
         tx_error = 1'b0;
         @(negedge clock);
         chk("tx_sym std", tx_sym, tx_std_sym);
      end
      @(negedge clock);
      tx_error = 1'b1;
      wr(PECQS_ADDR_EXT_CTRL, 16'h0000);
      #1 chk("tx_sym off", tx_sym, tx_std_sym);
      tend("code_map");
      for (int m = 0; m < 2; m++) begin
         wr(PECQS_ADDR_EXT_CTRL, m ? 16'h0008 : 16'h0000);
         for (int k = 0; k < 20; k++) begin
            if (k > 0) begin
               chk("tx_serial_out", m ? tx_serial_out ^ out_p : tx_serial_out, in_p);
            end
            out_p = tx_serial_out;
            in_p = 1'($urandom);
            tx_serial_in = in_p;
            @(negedge clock);
         end
      end
      tend("nrz");
      for (int c = 0; c < 8; c++) begin
         hw_mode = c[2];
         {rate_select_pin, duplex_select_pin} = c[1:0];
         {ctrl_rate_100, ctrl_duplex_full} = ~c[1:0];
         an_complete = c[0];
         signal_present = c[1];
         rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      end
      {hw_mode, rate_select_pin, duplex_select_pin, an_complete, signal_present} = 5'b11101;
      tend("rate_duplex");
      for (int i = 0; i < PECQS_NUM_EVT; i++) begin
         evt_in[i] = 1'b1;
         @(negedge clock);
         evt_in = '0;
         rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h01 << i, 1'b1));
         rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      end
      {rx_sym_valid, rx_sym_idle} = 2'b11;
      repeat (2) @(negedge clock);
      {rx_sym_valid, rx_sym_idle} = 2'b00;
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h20, 1'b1));
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      tend("sticky");
      an_state = 3'h3;
      @(negedge clock);
      an_state = 3'h1;
      @(negedge clock);
      rd(PECQS_ADDR_QSTAT, st_exp(3'h3, 8'h00, 1'b1));
      an_state = 3'h5;
      @(negedge clock);
      an_state = 3'h2;
      @(negedge clock);
      rd(PECQS_ADDR_QSTAT, st_exp(3'h5, 8'h00, 1'b1));
      an_restart = 1'b1;
      an_state = 3'h0;
      @(negedge clock);
      an_restart = 1'b0;
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      an_state = 3'h4;
      @(negedge clock);
      an_enable = 1'b0;
      an_state = 3'h0;
      @(negedge clock);
      an_enable = 1'b1;
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      tend("progress");
      link_valid = 1'b0;
      @(negedge clock);
      link_valid = 1'b1;
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b0));
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      tend("link");
      wr(PECQS_ADDR_QSTAT, 16'hFFFF);
      rd(PECQS_ADDR_QSTAT, st_exp(3'h0, 8'h00, 1'b1));
      rd(5'h05, 16'h0000);
      wr(PECQS_ADDR_EXT_CTRL, 16'h8008);
      rd(PECQS_ADDR_EXT_CTRL, ext_exp(16'h0008) | 16'h8000);
      wr(5'h05, 16'h0000);
      rd(PECQS_ADDR_EXT_CTRL, ext_exp(16'h0008));
      tend("refusals");
      repeat (2) @(negedge clock);
      test_done();
   end
endmodule
